/* File: bench/led_link_sva.sv */
// concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
module led_link_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic load_strobe,
    input wire logic cascade_data_out
);
    // ----------------------------------------
    // link timing and cascade
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic [7:0] sh_ff;
    // mirror of the near shift stage; clear pulses are not followed
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            sh_ff <= 8'h00;
        else if ($rose(serial_clk))
            sh_ff <= {sh_ff[6:0], serial_data_in};
    end
    sequence clk_rise;
        !serial_clk ##1 serial_clk;
    endsequence
    sequence clk_fall;
        serial_clk ##1 !serial_clk;
    endsequence
    chk_clk_high: assert property (clk_rise |-> serial_clk [*8] ##1 serial_clk [*8])
        else $error("clock high too short");
    chk_clk_low: assert property (clk_fall |-> !serial_clk [*8] ##1 !serial_clk [*8])
        else $error("clock low too short");
    chk_strobe_width: assert property (
        $rose(load_strobe) |-> load_strobe [*8] ##1 load_strobe [*8])
        else $error("strobe too short");
    chk_strobe_gap: assert property (
        $rose(load_strobe) |-> !$past(serial_clk) && !$past(serial_clk, 8))
        else $error("strobe too soon");
    chk_data_stable: assert property ($changed(serial_data_in) |-> !serial_clk)
        else $error("data moved while clock high");
    chk_casc_fall: assert property ($changed(cascade_data_out) |-> !serial_clk)
        else $error("cascade moved while clock high");
    chk_casc_delay: assert property (
        $rose(serial_clk) |-> cascade_data_out == sh_ff[7])
        else $error("cascade bit wrong");
    chk_strobe_quiet: assert property (load_strobe |-> !serial_clk)
        else $error("clock ran during strobe");
endmodule : led_link_sva

/* File: bench/serial_shift_latch_output_driver_tb.sv */
// self-checking bench: controller feeding two chained drivers
`timescale 1ns/1ps
module serial_shift_latch_output_driver_tb;
    // ----------------------------------------
    // stimulus and checks
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clr_n = 1'b1;
    logic dis = 1'b0;
    logic hot = 1'b0;
    logic frame_valid = 1'b0;
    logic [15:0] frame_data = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [31:0] seed = 32'h00017A49;
    logic [15:0] corner [3] = '{16'hFFFF, 16'h8001, 16'h7FFE};
    logic [7:0] near_q;
    logic [7:0] far_q;
    logic guard_q;
    logic guard2_q;
    logic ready_q;
    logic done_q;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    // take edge to done: sixteen clock periods, strobe gap, strobe width
    localparam logic [15:0] FRAME_CYC = 16'(led_latch_pkg::CHAIN_BITS
        * led_latch_pkg::CLOCK_PERIOD_MIN_CYC + led_latch_pkg::CLOCK_TO_STROBE_GAP_CYC
        + led_latch_pkg::STROBE_HIGH_MIN_CYC);
    led_link_if link();
    led_link_if link2();
    // far device rides on the near cascade output
    assign link2.serial_clk = link.serial_clk;
    assign link2.serial_data_in = link.cascade_data_out;
    assign link2.load_strobe = link.load_strobe;
    always #12.5 sys_clk = ~sys_clk;
    led_ctrl_end led_ctrl_end_inst (.sys_clk(sys_clk), .rst(rst), .link(link),
        .frame_valid(frame_valid), .frame_data(frame_data),
        .frame_ready(ready_q), .frame_done(done_q));
    led_driver_end led_driver_end_inst (.sys_clk(sys_clk), .rst(rst), .link(link),
        .clear_n(clr_n), .output_disable_in(dis), .over_temp_in(hot),
        .drain_outputs(near_q), .thermal_guard(guard_q));
    led_driver_end led_driver_end_inst2 (.sys_clk(sys_clk), .rst(rst), .link(link2),
        .clear_n(clr_n), .output_disable_in(dis), .over_temp_in(hot),
        .drain_outputs(far_q), .thermal_guard(guard2_q));
    led_link_sva led_link_sva_inst (.sys_clk(sys_clk), .rst(rst),
        .serial_clk(link.serial_clk), .serial_data_in(link.serial_data_in),
        .load_strobe(link.load_strobe), .cascade_data_out(link.cascade_data_out));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic [7:0] exp_drain(input logic [7:0] v, input logic d, input logic h);
        return (d | h) ? 8'h00 : v;
    endfunction : exp_drain
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : check
    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : check16
    task automatic print_verdict();
        $display("checks %0d fails %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // valid held one edge; a poked frame raises valid again while busy, to be refused
    task automatic send(input logic [15:0] v, input logic poke);
        int len;
        len = 0;
        @(posedge sys_clk);
        frame_valid <= 1'b1;
        frame_data <= v;
        last = v;
        @(posedge sys_clk);
        frame_valid <= 1'b0;
        for (int n = 0; n < 700; n++) begin
            @(posedge sys_clk);
            if (poke && n < 42) begin
                frame_valid <= (n == 40);
                frame_data <= ~v;
            end
            #1;
            len++;
            if (n == 0) check("busy ready", 8'h00, {7'h00, ready_q});
            if (done_q === 1'b1) break;
        end
        check16("frame len", FRAME_CYC, 16'(len));
        check("idle ready", 8'h01, {7'h00, ready_q});
        check("near cascade", {7'h00, last[7]}, {7'h00, link.cascade_data_out});
        check("far cascade", {7'h00, last[15]}, {7'h00, link2.cascade_data_out});
    endtask : send
    task automatic apply(input logic d, input logic h);
        @(posedge sys_clk);
        dis <= d;
        hot <= h;
        repeat (3) @(posedge sys_clk);
        #1;
        check("near", exp_drain(last[7:0], d, h), near_q);
        check("far", exp_drain(last[15:8], d, h), far_q);
        check("guard", {7'h00, h & ~d}, {7'h00, guard_q});
        check("far guard", {7'h00, h & ~d}, {7'h00, guard2_q});
    endtask : apply
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check("reset", 8'h00, near_q);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            send(i > 4 ? corner[i - 5] : seed[15:0], i[0]);
            check("near", last[7:0], near_q);
            check("far", last[15:8], far_q);
        end
        apply(1'b1, 1'b1);
        apply(1'b0, 1'b1);
        for (int i = 0; i < 7; i++) apply(i[0], 1'b0);
        @(posedge sys_clk);
        clr_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("near", 8'h00, near_q);
        check("far", 8'h00, far_q);
        print_verdict();
    end
endmodule : serial_shift_latch_output_driver_tb

/* File: shared/led_latch_pkg.sv */
// constants and types shared by the serial latch driver ends
//
// Summary of operation
// - eight bits msb first; one turns output on
// - disable high forces all outputs off
// - disable high suspends thermal guard
// - pwm on disable gates enabled outputs
// - cascade output changes on falling clock
// - two chained devices take sixteen-bit frames
// - data reaches next device after eight clocks
// - clock period 800 ns, phases 380 ns
// - strobe high at least 380 ns
// - 200 ns from last rise to strobe
// - rising clock shifts serial data in
// - rising strobe copies shift into holding
// - clear low zeroes both registers
package led_latch_pkg;
    localparam int FRAME_BITS = 8;
    localparam int CHAIN_BITS = 16;
    localparam int CLK_NS = 25;
    localparam int CLOCK_PERIOD_MIN_NS = 800;
    localparam int CLOCK_HIGH_MIN_NS = 380;
    localparam int CLOCK_LOW_MIN_NS = 380;
    localparam int STROBE_HIGH_MIN_NS = 380;
    localparam int CLOCK_TO_STROBE_GAP_NS = 200;
    // least times round up
    localparam int CLOCK_HIGH_MIN_CYC = (CLOCK_HIGH_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLOCK_LOW_MIN_CYC = (CLOCK_LOW_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLOCK_PERIOD_MIN_CYC = (CLOCK_PERIOD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_HIGH_MIN_CYC = (STROBE_HIGH_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLOCK_TO_STROBE_GAP_CYC =
        (CLOCK_TO_STROBE_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] FRAME_RESET = 8'h00;
    localparam logic [15:0] CHAIN_RESET = 16'h0000;
    localparam logic [5:0] CNT_RESET = 6'h00;
    localparam logic [4:0] BIT_RESET = 5'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOW = 3'b001,
        ST_HIGH = 3'b011,
        ST_GAP = 3'b010,
        ST_STROBE = 3'b110
    } ctl_state_t;
endpackage : led_latch_pkg

/* File: shared/led_link_if.sv */
// four-wire serial link joining controller and driver
`timescale 1ns/1ps
interface led_link_if;
    logic serial_clk;
    logic serial_data_in;
    logic load_strobe;
    logic cascade_data_out;

    modport controller (
        output serial_clk,
        output serial_data_in,
        output load_strobe,
        input cascade_data_out
    );
    modport driver (
        input serial_clk,
        input serial_data_in,
        input load_strobe,
        output cascade_data_out
    );
endinterface : led_link_if

/* File: src/led_ctrl_end.sv */
// controller end: sends 16-bit chained frame, then strobes
`timescale 1ns/1ps
module led_ctrl_end (
    input wire logic sys_clk,
    input wire logic rst,
    led_link_if.controller link,
    input wire logic frame_valid,
    input wire logic [15:0] frame_data,
    output logic frame_ready,
    output logic frame_done
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        led_latch_pkg::ctl_state_t state;
        logic [15:0] data;
        logic [4:0] bits;
        logic [5:0] cnt;
        logic sclk;
        logic sdat;
        logic strobe;
        logic ready;
        logic done;
    } ctl_t;

    ctl_t st_ff;
    ctl_t nxt_st;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.cnt = st_ff.cnt + 6'h01;
        unique case (st_ff.state)
            led_latch_pkg::ST_IDLE: begin
                nxt_st.ready = 1'b1;
                if (frame_valid && st_ff.ready) begin
                    nxt_st.ready = 1'b0;
                    nxt_st.data = frame_data;
                    nxt_st.bits = led_latch_pkg::BIT_RESET;
                    nxt_st.cnt = led_latch_pkg::CNT_RESET;
                    nxt_st.sdat = frame_data[15];
                    nxt_st.state = led_latch_pkg::ST_LOW;
                end
            end
            led_latch_pkg::ST_LOW: begin
                // data moved only with clock low
                if (st_ff.cnt == 6'(led_latch_pkg::CLOCK_LOW_MIN_CYC - 1)) begin
                    nxt_st.sclk = 1'b1;
                    nxt_st.cnt = led_latch_pkg::CNT_RESET;
                    nxt_st.state = led_latch_pkg::ST_HIGH;
                end
            end
            led_latch_pkg::ST_HIGH: begin
                // low + high sum to 32 cycles, 800 ns
                if (st_ff.cnt == 6'(led_latch_pkg::CLOCK_PERIOD_MIN_CYC
                                    - led_latch_pkg::CLOCK_LOW_MIN_CYC - 1)) begin
                    nxt_st.sclk = 1'b0;
                    nxt_st.cnt = led_latch_pkg::CNT_RESET;
                    nxt_st.bits = st_ff.bits + 5'h01;
                    nxt_st.data = {st_ff.data[14:0], 1'b0};
                    nxt_st.sdat = st_ff.data[14];
                    if (st_ff.bits == 5'(led_latch_pkg::CHAIN_BITS - 1)) begin
                        nxt_st.state = led_latch_pkg::ST_GAP;
                    end else begin
                        nxt_st.state = led_latch_pkg::ST_LOW;
                    end
                end
            end
            led_latch_pkg::ST_GAP: begin
                // counted from the clock fall, safely past 200 ns from the rise
                if (st_ff.cnt == 6'(led_latch_pkg::CLOCK_TO_STROBE_GAP_CYC - 1)) begin
                    nxt_st.strobe = 1'b1;
                    nxt_st.cnt = led_latch_pkg::CNT_RESET;
                    nxt_st.state = led_latch_pkg::ST_STROBE;
                end
            end
            led_latch_pkg::ST_STROBE: begin
                if (st_ff.cnt == 6'(led_latch_pkg::STROBE_HIGH_MIN_CYC - 1)) begin
                    nxt_st.strobe = 1'b0;
                    nxt_st.done = 1'b1;
                    nxt_st.ready = 1'b1;
                    nxt_st.state = led_latch_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_st.state = led_latch_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.serial_clk = st_ff.sclk;
    assign link.serial_data_in = st_ff.sdat;
    assign link.load_strobe = st_ff.strobe;
    assign frame_ready = st_ff.ready;
    assign frame_done = st_ff.done;
endmodule : led_ctrl_end

/* File: src/led_driver_end.sv */
// device end: shift register, holding register, gated drain outputs
`timescale 1ns/1ps
module led_driver_end (
    input wire logic sys_clk,
    input wire logic rst,
    led_link_if.driver link,
    input wire logic clear_n,
    input wire logic output_disable_in,
    input wire logic over_temp_in,
    output logic [7:0] drain_outputs,
    output logic thermal_guard
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] shift;
        logic [7:0] hold;
        logic clk_prev;
        logic strobe_prev;
        logic cascade;
        logic [7:0] drain;
        logic guard;
    } drv_t;

    drv_t st_ff;
    drv_t nxt_st;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // one rising-edge test shared by the clock and strobe pins
    function automatic logic rose_now(input logic now_lvl, input logic prev_lvl);
        return now_lvl && !prev_lvl;
    endfunction : rose_now

    // pins are sampled as synchronous; edges found against last sample
    always_comb begin
        nxt_st = st_ff;
        nxt_st.clk_prev = link.serial_clk;
        nxt_st.strobe_prev = link.load_strobe;
        if (rose_now(link.serial_clk, st_ff.clk_prev)) begin
            nxt_st.shift = {st_ff.shift[6:0], link.serial_data_in};
        end
        if (!link.serial_clk && st_ff.clk_prev) begin
            nxt_st.cascade = st_ff.shift[7];
        end
        if (rose_now(link.load_strobe, st_ff.strobe_prev)) begin
            nxt_st.hold = st_ff.shift;
        end
        // disable wins over holding data, so a pwm wave on it dims
        nxt_st.drain = output_disable_in ? led_latch_pkg::FRAME_RESET
                                         : nxt_st.hold;
        // guard idle while disabled
        nxt_st.guard = over_temp_in && !output_disable_in;
        if (st_ff.guard) begin
            nxt_st.drain = led_latch_pkg::FRAME_RESET;
        end
        if (!clear_n) begin
            nxt_st.shift = led_latch_pkg::FRAME_RESET;
            nxt_st.hold = led_latch_pkg::FRAME_RESET;
            nxt_st.drain = led_latch_pkg::FRAME_RESET;
            nxt_st.cascade = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign drain_outputs = st_ff.drain;
    assign thermal_guard = st_ff.guard;
    assign link.cascade_data_out = st_ff.cascade;
endmodule : led_driver_end
